// [inc/aor_params.svh]
// Constants for the option, gap, edge-count and result register block.
// Assumes a 25 MHz system clock and an I2C master on the far side.
// Operation
// - Offset codes 00/01/10/11 give 0, 15, 31, 63 counts at zero input.
// - Code 00 disables offset; upper option bits are written zero by host.
// - In sync start-stop mode offsets are period times clock over 2^7/2^11/2^15.
// - Active offset is added to input current path and conversion result.
// - Offset field returns to default at reset and on leaving measurement.
// - Continuous mode gap is 1 us plus 4 us per count, 5 to 1021 us.
// - Command mode gap delays integration start by 1 to 255 us.
// - Gap register is unused in both synchronous modes.
// - Gap register resets to 20h; writing zero is ignored.
// - Sync start-stop ends integration after programmed falling sync edges, 1 to 255.
// - Edge-count register resets to 01h; writing zero is ignored.
// - Four read-only 16-bit channel results at addresses 00 to 03.
// - Addresses 04 and 05 hold 24-bit integration time, low 20 bits meaningful.
// - Time result valid only in sync start-stop with time measure enabled.
// - Every conversion end refreshes the four channel results; time words only in sync start-stop with time measure.
// - Result refresh waits while the host is reading results.
// - Upper part of the time count appears as word at address 5.
// - I2C slave only, address 11101 then the two select pins.
// - Serial interface follows fast-mode I2C protocol and timing.
// - Time capture only when time measure enable bit is set.
// - Mode field: continuous 00, command 01, sync start 10, sync start-stop 11.
// - Sync start-stop uses sync signal, ignoring programmed integration period.
`ifndef AOR_PARAMS_SVH
`define AOR_PARAMS_SVH
`define AOR_ADDR_CH0 8'h00
`define AOR_ADDR_CH3 8'h03
`define AOR_ADDR_TLO 8'h04
`define AOR_ADDR_THI 8'h05
`define AOR_ADDR_OPT 8'h08
`define AOR_ADDR_GAP 8'h09
`define AOR_ADDR_EDGES 8'h0a
`define AOR_OPT_RST 2'h0
`define AOR_GAP_RST 8'h20
`define AOR_EDGES_RST 8'h01
`define AOR_OFS_1 16'h000f
`define AOR_OFS_2 16'h001f
`define AOR_OFS_3 16'h003f
`define AOR_SHIFT_1 7
`define AOR_SHIFT_2 11
`define AOR_SHIFT_3 15
`define AOR_MODE_CONTINUOUS_MODE 2'h0
`define AOR_MODE_CMD 2'h1
`define AOR_MODE_SYNC_START_MODE 2'h2
`define AOR_MODE_SYNC_START_STOP_MODE 2'h3
`define AOR_SLAVE_BASE 5'h1d
`define AOR_CLK_PERIOD_NS 40
`define AOR_US_NS 1000
`define AOR_US_CYC ((`AOR_US_NS + `AOR_CLK_PERIOD_NS - 1) / `AOR_CLK_PERIOD_NS)
`define AOR_GAP_BASE_US 10'h001
`define AOR_FCLK_INC 12'h080
`define AOR_FCLK_MOD 12'h0c35
`endif

// [inc/aor_pkg.sv]
// Types for the option, gap, edge-count and result register block.
// Assumes aor_params.svh supplies the numeric constants.
package aor_pkg;
    typedef enum logic [2:0] {I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SEND, I2C_RACK} aor_i2c_e;
    typedef enum logic [2:0] {SQ_IDLE, SQ_GAP, SQ_WAIT_SYNC, SQ_INTEG, SQ_CONV} aor_seq_e;
    typedef struct packed {
        logic [3:0][15:0] ch;
    } aor_conv_s;
    typedef struct packed {
        aor_i2c_e i2c_st;
        logic scl_d;
        logic sda_d;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [1:0] byte_idx;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic phase;
        logic sda_drive;
        logic read_active;
        logic [1:0] opt_code;
        logic [7:0] gap;
        logic [7:0] edges;
        logic [3:0][15:0] res;
        logic [23:0] tres;
        logic pend;
        logic [3:0][15:0] pend_res;
        logic [23:0] pend_t;
        aor_seq_e seq_st;
        logic meas_d;
        logic sync_d;
        logic [11:0] fclk_acc;
        logic [4:0] us_div;
        logic [9:0] us_cnt;
        logic [19:0] int_cnt;
        logic [7:0] edge_cnt;
        logic [19:0] tmeas;
        logic [19:0] tlast;
        logic [15:0] off_val;
    } aor_state_s;
endpackage : aor_pkg

// [src/aor_block.sv]
// Measurement sequencer, option/gap/edge registers and result bank behind an I2C slave.
// Assumes synchronous pin inputs and an analog front end that answers each
// integration with one i_conv_valid pulse carrying the four raw channel values.
`include "aor_params.svh"
`timescale 1ns/1ps
`default_nettype none
module aor_block (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // I2C pins, open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_addr_select_high,
    input wire logic i_addr_select_low,
    // Configuration held elsewhere in the device
    input wire logic i_measure_state,
    input wire logic [1:0] i_meas_mode,
    input wire logic i_time_measure_enable,
    input wire logic [19:0] i_integration_period,
    input wire logic i_cmd_start,
    input wire logic i_sync,
    // Analog front end
    input wire logic i_conv_valid,
    input wire aor_pkg::aor_conv_s i_conv,
    output logic o_integ_active,
    output logic [1:0] o_offset_code,
    output logic [15:0] o_offset_value
);
    import aor_pkg::*;

    aor_state_s r;
    aor_state_s n;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic load;
    logic wr;
    logic fclk_tick;
    logic us_tick;
    logic sync_fall;
    logic sync_start_stop_mode;
    logic [9:0] gap_us;
    logic [3:0][15:0] new_res;
    logic [23:0] new_t;
    logic [15:0] ofs_now;

    // Saturating add keeps an offset result from wrapping past full scale
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hffff : s[15:0];
    endfunction : sat_add

    // Offset for the present code; sync start-stop scales the measured period
    function automatic logic [15:0] ofs_of(input logic [1:0] code, input logic sd,
                                           input logic [19:0] t);
        ofs_of = 16'h0000;
        case (code)
            2'h1: ofs_of = sd ? 16'(t >> `AOR_SHIFT_1) : `AOR_OFS_1;
            2'h2: ofs_of = sd ? 16'(t >> `AOR_SHIFT_2) : `AOR_OFS_2;
            2'h3: ofs_of = sd ? 16'(t >> `AOR_SHIFT_3) : `AOR_OFS_3;
            default: ofs_of = 16'h0000;
        endcase
    endfunction : ofs_of

    // Byte seen by the master at a pointer; result words go low byte first
    function automatic logic [7:0] rd_byte(input aor_state_s s);
        logic [15:0] w;
        w = 16'h0000;
        if (s.ptr <= `AOR_ADDR_CH3) begin
            w = s.res[s.ptr[1:0]];
        end else if (s.ptr == `AOR_ADDR_TLO) begin
            w = s.tres[15:0];
        end else if (s.ptr == `AOR_ADDR_THI) begin
            w = {8'h00, s.tres[23:16]};
        end else if (s.ptr == `AOR_ADDR_OPT) begin
            w = {14'h0000, s.opt_code};
        end else if (s.ptr == `AOR_ADDR_GAP) begin
            w = {8'h00, s.gap};
        end else if (s.ptr == `AOR_ADDR_EDGES) begin
            w = {8'h00, s.edges};
        end
        rd_byte = (s.phase && s.ptr <= `AOR_ADDR_THI) ? w[15:8] : w[7:0];
    endfunction : rd_byte

    // Next state of the whole block
    always_comb begin
        n = r;
        load = 1'b0;
        wr = 1'b0;
        scl_rise = i_scl & ~r.scl_d;
        scl_fall = ~i_scl & r.scl_d;
        i2c_start = r.scl_d & i_scl & r.sda_d & ~i_sda;
        i2c_stop = r.scl_d & i_scl & ~r.sda_d & i_sda;
        sync_fall = r.sync_d & ~i_sync;
        sync_start_stop_mode = (i_meas_mode == `AOR_MODE_SYNC_START_STOP_MODE);
        n.scl_d = i_scl;
        n.sda_d = i_sda;
        n.sync_d = i_sync;
        n.meas_d = i_measure_state;

        // Slave state machine; bits change only while SCL is low
        if (i2c_start) begin
            n.i2c_st = I2C_RECV;
            n.bit_cnt = 4'h0;
            n.byte_idx = 2'h0;
            n.sda_drive = 1'b0;
            n.read_active = 1'b0;
        end else if (i2c_stop) begin
            n.i2c_st = I2C_IDLE;
            n.sda_drive = 1'b0;
            n.read_active = 1'b0;
        end else begin
            case (r.i2c_st)
                I2C_RECV: begin
                    if (scl_rise && r.bit_cnt != 4'h8) begin
                        n.shreg = {r.shreg[6:0], i_sda};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == 4'h8) begin
                        n.bit_cnt = 4'h0;
                        if (r.byte_idx != 2'h0) begin
                            n.i2c_st = I2C_ACK;
                            n.sda_drive = 1'b1;
                            wr = (r.byte_idx == 2'h2);
                            if (r.byte_idx == 2'h1) begin
                                n.ptr = r.shreg;
                                n.phase = 1'b0;
                            end
                        end else if (r.shreg[7:1] == {`AOR_SLAVE_BASE, i_addr_select_high,
                                                      i_addr_select_low}) begin
                            n.i2c_st = I2C_ACK;
                            n.sda_drive = 1'b1;
                            n.rw = r.shreg[0];
                        end else begin
                            n.i2c_st = I2C_IDLE; // Not addressed, stay off the bus
                        end
                    end
                end
                I2C_ACK: begin
                    if (scl_fall) begin
                        n.sda_drive = 1'b0;
                        if (r.byte_idx != 2'h2) begin
                            n.byte_idx = r.byte_idx + 2'h1;
                        end
                        if (r.byte_idx == 2'h0 && r.rw) begin
                            load = 1'b1;
                            n.read_active = 1'b1;
                        end else begin
                            n.i2c_st = I2C_RECV;
                        end
                    end
                end
                I2C_SEND: begin
                    if (scl_fall) begin
                        if (r.bit_cnt == 4'h7) begin
                            n.sda_drive = 1'b0;
                            n.i2c_st = I2C_RACK;
                        end else begin
                            n.bit_cnt = r.bit_cnt + 4'h1;
                            n.shreg = {r.shreg[6:0], 1'b0};
                            n.sda_drive = ~r.shreg[6];
                        end
                    end
                end
                I2C_RACK: begin
                    if (scl_rise) begin
                        n.nack = i_sda;
                    end else if (scl_fall) begin
                        if (r.nack) begin
                            n.i2c_st = I2C_IDLE;
                        end else begin
                            load = 1'b1;
                        end
                    end
                end
                default: begin
                    n.i2c_st = I2C_IDLE;
                end
            endcase
        end

        // Load a read byte and auto-increment; result words take two bytes
        if (load) begin
            n.shreg = rd_byte(r);
            n.sda_drive = ~n.shreg[7];
            n.bit_cnt = 4'h0;
            n.i2c_st = I2C_SEND;
            if (r.ptr <= `AOR_ADDR_THI && !r.phase) begin
                n.phase = 1'b1;
            end else begin
                n.phase = 1'b0;
                n.ptr = r.ptr + 8'h01;
            end
        end

        // Register writes; zero is refused for gap and edge count
        if (wr) begin
            n.ptr = r.ptr + 8'h01;
            if (r.ptr == `AOR_ADDR_OPT) begin
                n.opt_code = r.shreg[1:0];
            end else if (r.ptr == `AOR_ADDR_GAP && r.shreg != 8'h00) begin
                n.gap = r.shreg;
            end else if (r.ptr == `AOR_ADDR_EDGES && r.shreg != 8'h00) begin
                n.edges = r.shreg;
            end
        end

        // Leaving measurement state restores the offset default
        if (r.meas_d && !i_measure_state) begin
            n.opt_code = `AOR_OPT_RST;
        end

        // Internal 1.024 MHz tick and 1 us tick
        fclk_tick = (r.fclk_acc + `AOR_FCLK_INC) >= `AOR_FCLK_MOD;
        n.fclk_acc = fclk_tick ? r.fclk_acc + `AOR_FCLK_INC - `AOR_FCLK_MOD
                               : r.fclk_acc + `AOR_FCLK_INC;
        us_tick = (r.us_div == 5'(`AOR_US_CYC - 1));
        n.us_div = us_tick ? 5'h00 : r.us_div + 5'h01;

        // Gap length depends on the mode
        gap_us = (i_meas_mode == `AOR_MODE_CONTINUOUS_MODE) ? `AOR_GAP_BASE_US + {r.gap, 2'b00}
                                                : {2'b00, r.gap};

        // Measurement sequencer
        case (r.seq_st)
            SQ_IDLE: begin
                n.us_cnt = 10'h000;
                n.us_div = 5'h00;
                if (i_measure_state) begin
                    if (i_meas_mode == `AOR_MODE_CONTINUOUS_MODE) begin
                        n.seq_st = SQ_GAP;
                    end else if (i_meas_mode == `AOR_MODE_CMD) begin
                        if (i_cmd_start) begin
                            n.seq_st = SQ_GAP;
                        end
                    end else begin
                        n.seq_st = SQ_WAIT_SYNC;
                    end
                end
            end
            SQ_GAP: begin
                if (us_tick) begin
                    n.us_cnt = r.us_cnt + 10'h001;
                    if (r.us_cnt + 10'h001 >= gap_us) begin
                        n.seq_st = SQ_INTEG;
                        n.int_cnt = 20'h00000;
                        n.tmeas = 20'h00000;
                    end
                end
            end
            SQ_WAIT_SYNC: begin
                if (sync_fall) begin
                    n.seq_st = SQ_INTEG;
                    n.int_cnt = 20'h00000;
                    n.tmeas = 20'h00000;
                    n.edge_cnt = 8'h00;
                end
            end
            SQ_INTEG: begin
                if (fclk_tick) begin
                    n.int_cnt = r.int_cnt + 20'h00001;
                    n.tmeas = r.tmeas + 20'h00001;
                end
                if (sync_start_stop_mode) begin
                    if (sync_fall) begin
                        n.edge_cnt = r.edge_cnt + 8'h01;
                        if (r.edge_cnt + 8'h01 >= r.edges) begin
                            n.seq_st = SQ_CONV;
                            n.tlast = n.tmeas;
                        end
                    end
                end else if (fclk_tick && r.int_cnt + 20'h00001 >= i_integration_period) begin
                    n.seq_st = SQ_CONV;
                    n.tlast = n.tmeas;
                end
            end
            SQ_CONV: begin
                n.us_cnt = 10'h000;
                n.us_div = 5'h00; // Next gap starts on a whole microsecond
                if (i_conv_valid) begin
                    n.seq_st = (i_meas_mode == `AOR_MODE_CONTINUOUS_MODE) ? SQ_GAP : SQ_IDLE;
                end
            end
            default: begin
                n.seq_st = SQ_IDLE;
            end
        endcase
        if (!i_measure_state) begin
            n.seq_st = SQ_IDLE;
        end

        // Offset driven to the front end and added to results
        ofs_now = ofs_of(r.opt_code, sync_start_stop_mode, r.tlast);
        n.off_val = ofs_now;
        for (int k = 0; k < 4; k++) begin
            new_res[k] = sat_add(i_conv.ch[k], ofs_now);
        end
        new_t = (sync_start_stop_mode && i_time_measure_enable) ? {4'h0, r.tlast} : r.tres;

        // Refresh results, deferred while a read transaction is open
        if (r.pend && !r.read_active) begin
            n.res = r.pend_res;
            n.tres = r.pend_t;
            n.pend = 1'b0;
        end
        if (r.seq_st == SQ_CONV && i_conv_valid) begin
            if (r.read_active) begin
                n.pend = 1'b1;
                n.pend_res = new_res;
                n.pend_t = new_t;
            end else begin
                n.res = new_res;
                n.tres = new_t;
                n.pend = 1'b0;
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r <= '0;
            r.i2c_st <= I2C_IDLE;
            r.seq_st <= SQ_IDLE;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.sync_d <= 1'b1;
            r.opt_code <= `AOR_OPT_RST;
            r.gap <= `AOR_GAP_RST;
            r.edges <= `AOR_EDGES_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = ~r.sda_drive;
    assign o_integ_active = (r.seq_st == SQ_INTEG);
    assign o_offset_code = r.opt_code;
    assign o_offset_value = r.off_val;
endmodule : aor_block
`default_nettype wire

// [verification/aor_block_chk.sv]
// Pin-level checker for the option, gap, edge-count and result block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module aor_block_chk (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Watched pins
    input wire logic i_scl,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic i_measure_state,
    input wire logic [1:0] i_meas_mode,
    input wire logic i_cmd_start,
    input wire logic i_sync,
    input wire logic o_integ_active,
    input wire logic [1:0] o_offset_code,
    input wire logic [15:0] o_offset_value
);
    localparam logic [15:0] ofs_tab [4] = '{16'h0000, 16'h000f, 16'h001f, 16'h003f};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Assertions on the serial pins and the measurement outputs
    a_sda_zero: assert property (o_sda_out == 1'b0)
        else $error("sda data not zero");
    a_oe_scl_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("sda moved while scl high");
    a_reset_idle: assert property ($rose(i_rst_n) |->
        o_sda_oe_n && !o_integ_active && o_offset_code == 2'h0)
        else $error("pins not idle after reset");
    a_opt_clear: assert property ($fell(i_measure_state) |-> ##[1:2] o_offset_code == 2'h0)
        else $error("offset code kept");
    a_ofs_table: assert property (i_meas_mode != 2'h3 && $past(i_meas_mode) != 2'h3
        && $past(i_rst_n) |-> o_offset_value == ofs_tab[$past(o_offset_code)])
        else $error("offset value wrong");
    a_cmd_gap: assert property (i_meas_mode == 2'h1 && i_cmd_start && !o_integ_active
        |=> !o_integ_active [*8])
        else $error("command gap too short");
    a_sync_start_mode_start: assert property (i_meas_mode == 2'h2 && i_measure_state && $fell(i_sync)
        && !o_integ_active |-> ##[1:4] o_integ_active)
        else $error("sync start late");
    a_sync_start_stop_mode_stop: assert property ($fell(o_integ_active) && i_meas_mode == 2'h3
        && $past(i_measure_state) |-> !i_sync
        && ($past(i_sync, 2) || $past(i_sync, 3) || $past(i_sync, 4)))
        else $error("stop without sync edge");
    // Main scenarios reached
    c_cmd: cover property (i_meas_mode == 2'h1 && i_cmd_start);
    c_sync_start_stop_mode: cover property ($fell(o_integ_active) && i_meas_mode == 2'h3);
    c_ofs3: cover property (o_offset_code == 2'h3);
endmodule : aor_block_chk
bind aor_block aor_block_chk u_chk (.*);
`default_nettype wire

// [verification/aor_i2c_mst.sv]
// I2C master model that paces the block's serial pins.
// Assumes a pull-up on SDA; the master only pulls it low.
`timescale 1ns/1ps
`default_nettype none
module aor_i2c_mst (
    // Pacing clock
    input wire logic i_sys_clk,
    // Wire levels
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    int qn = 16; // Quarter bit; 64 clocks a bit stays under 400 kHz
    // Idle bus
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Quarter bit wait ending just after an edge
    task automatic q();
        repeat (qn) @(posedge i_sys_clk);
        #1;
    endtask : q
    // Start or repeated start, SDA falls while SCL is high
    task automatic start();
        o_sda_low = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_low = 1'b1;
        q();
        o_scl = 1'b0;
        q();
    endtask : start
    // One bit, data changed only while SCL is low
    task automatic bitx(input logic b, output logic r);
        o_sda_low = ~b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask : bitx
    // Eight bits MSB first and the ninth bit
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
        output logic s);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(b9, s);
    endtask : xfer
    // Stop, SDA rises while SCL is high
    task automatic stop();
        o_sda_low = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_low = 1'b0;
        q();
    endtask : stop
endmodule : aor_i2c_mst
`default_nettype wire

// [verification/aor_block_tb.sv]
// Self-checking bench for the option, gap, edge-count and result block.
// Assumes the master model and the bound checker beside the block.
`include "aor_params.svh"
`timescale 1ns/1ps
`default_nettype none
module aor_block_tb;
    import aor_pkg::*;
    typedef struct packed {
        logic [1:0] code;
        logic [15:0] base;
    } aor_row_s;
    localparam logic [6:0] slv_addr = {`AOR_SLAVE_BASE, 2'b10};
    localparam logic [15:0] ofs [4] = '{16'h0000, 16'h000f, 16'h001f, 16'h003f};
    localparam aor_row_s rows [4] = '{'{2'h0, 16'h1000}, '{2'h1, 16'h2000},
        '{2'h2, 16'h0040}, '{2'h3, 16'hfff0}};
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic scl, sda_low, sda, oe_n, sda_out, act, ak;
    logic meas = 1'b0, tme = 1'b0, cmd = 1'b0, syn = 1'b1, cv = 1'b0;
    logic [1:0] mode = 2'h1, code;
    logic [15:0] oval;
    logic [19:0] per = 20'h0_0010;
    logic [23:0] t0;
    aor_conv_s conv = '0;
    logic [7:0] rb [11];
    int failures = 0, checked = 0, cyc = 0, c;
    always #20 i_sys_clk = ~i_sys_clk;
    // Open-drain data wire with pull-up
    assign sda = ~sda_low & oe_n;
    aor_block dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_addr_select_high(1'b1),
        .i_addr_select_low(1'b0), .i_measure_state(meas), .i_meas_mode(mode),
        .i_time_measure_enable(tme), .i_integration_period(per), .i_cmd_start(cmd),
        .i_sync(syn), .i_conv_valid(cv), .i_conv(conv), .o_integ_active(act),
        .o_offset_code(code), .o_offset_value(oval));
    aor_i2c_mst mst (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Hang guard
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s: %h vs %h", $time, m, seen, exp);
        end
    endtask : chk
    task automatic tk(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask : tk
    // Cycles until the integration flag reaches lvl, bounded
    task automatic wt(input logic lvl);
        c = 0;
        while (act !== lvl && c < 30000) begin
            tk(1);
            c++;
        end
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        mst.start();
        mst.xfer({slv_addr, 1'b0}, 1'b1, r, ak);
        chk(ak, 1'b0, "ack");
        mst.xfer(a, 1'b1, r, ak);
        mst.xfer(d, 1'b1, r, ak);
        mst.stop();
    endtask : wr
    // Pointer, repeated start, k bytes, NACK on the last
    task automatic rd(input logic [7:0] a, input int k);
        logic [7:0] r;
        mst.start();
        mst.xfer({slv_addr, 1'b0}, 1'b1, r, ak);
        mst.xfer(a, 1'b1, r, ak);
        mst.start();
        mst.xfer({slv_addr, 1'b1}, 1'b1, r, ak);
        for (int i = 0; i < k; i++) mst.xfer(8'hff, i == k - 1, rb[i], ak);
        mst.stop();
    endtask : rd
    task automatic conv_in(input logic [15:0] b);
        for (int i = 0; i < 4; i++) conv.ch[i] = b + 16'(i);
        cv = 1'b1;
        tk(1);
        cv = 1'b0;
    endtask : conv_in
    // Channel words, low byte first, saturated base plus offset
    task automatic chk_res(input logic [15:0] b, input logic [15:0] o);
        logic [16:0] s;
        for (int i = 0; i < 4; i++) begin
            s = {1'b0, b} + 17'(i) + {1'b0, o};
            chk({rb[2 * i + 1], rb[2 * i]}, s[16] ? 16'hffff : s[15:0], "res");
        end
    endtask : chk_res
    task automatic cmd_go();
        cmd = 1'b1;
        tk(1);
        cmd = 1'b0;
        wt(1'b1);
        chk(c >= `AOR_US_CYC - 3 && c <= `AOR_US_CYC + 3, 1'b1, "cmd gap");
        wt(1'b0);
    endtask : cmd_go
    task automatic sync_fall(input int k);
        syn = 1'b0;
        tk(4);
        syn = 1'b1;
        tk(k);
    endtask : sync_fall
    // Main sequence: reset, register and address cases, then rows, then hand-written cases
    initial begin
        tk(6);
        chk({oe_n, act, code}, 4'b1000, "reset pins");
        i_rst_n = 1'b1;
        rd(`AOR_ADDR_OPT, 3);
        chk({rb[0], rb[1], rb[2]}, 24'h00_2001, "reset regs");
        wr(`AOR_ADDR_GAP, 8'h00);
        wr(`AOR_ADDR_EDGES, 8'h00);
        wr(`AOR_ADDR_OPT, 8'h03);
        rd(`AOR_ADDR_OPT, 3);
        chk({rb[0], rb[1], rb[2]}, 24'h03_2001, "zero writes");
        mst.start();
        mst.xfer({`AOR_SLAVE_BASE, 2'b01, 1'b0}, 1'b1, rb[0], ak);
        mst.stop();
        chk(ak, 1'b1, "foreign addr");
        wr(`AOR_ADDR_GAP, 8'h01);
        meas = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`AOR_ADDR_OPT, {6'h00, rows[i].code});
            tk(3);
            chk(code, rows[i].code, "code");
            chk(oval, ofs[rows[i].code], "ofs");
            cmd_go();
            conv_in(rows[i].base);
            tk(2);
            rd(`AOR_ADDR_CH0, 8);
            chk_res(rows[i].base, ofs[rows[i].code]);
        end
        meas = 1'b0;
        tk(3);
        chk(code, 2'h0, "opt clear");
        meas = 1'b1;
        fork
            rd(`AOR_ADDR_CH0, 8);
            begin
                tk(2500);
                cmd_go();
                conv_in(16'h3000);
            end
        join
        chk_res(16'hfff0, 16'h003f);
        rd(`AOR_ADDR_CH0, 8);
        chk_res(16'h3000, 16'h0000);
        mode = `AOR_MODE_CONTINUOUS_MODE; // no result reads while converting
        for (int i = 0; i < 2; i++) begin
            wt(1'b1);
            chk(c >= 5 * `AOR_US_CYC - 3 && c <= 5 * `AOR_US_CYC + 3, 1'b1, "continuous_mode");
            wt(1'b0);
            conv_in(16'h0500);
        end
        meas = 1'b0;
        mode = `AOR_MODE_SYNC_START_STOP_MODE;
        tme = 1'b1;
        wr(`AOR_ADDR_EDGES, 8'h02);
        meas = 1'b1;
        tk(2);
        sync_fall(60);
        chk(act, 1'b1, "sync_start_stop_mode start");
        sync_fall(400);
        chk(act, 1'b1, "period ignored");
        sync_fall(2);
        chk(act, 1'b0, "sync_start_stop_mode stop");
        conv_in(16'h0100);
        tk(2);
        rd(`AOR_ADDR_CH0, 11);
        t0 = {rb[10], rb[9], rb[8]};
        chk(t0[23:20], 4'h0, "time top");
        chk(t0 >= 17 && t0 <= 21, 1'b1, "time");
        rd(`AOR_ADDR_THI, 2);
        chk({rb[1], rb[0]}, {8'h00, t0[23:16]}, "word 5");
        tme = 1'b0;
        sync_fall(60);
        sync_fall(800);
        sync_fall(2);
        conv_in(16'h0100);
        tk(2);
        rd(`AOR_ADDR_TLO, 2);
        chk({rb[1], rb[0]}, t0[15:0], "time kept");
        meas = 1'b0;
        mode = `AOR_MODE_SYNC_START_MODE;
        wr(`AOR_ADDR_GAP, 8'h20);
        meas = 1'b1;
        tk(2);
        syn = 1'b0;
        wt(1'b1);
        chk(c <= 4, 1'b1, "sync_start_mode start");
        syn = 1'b1;
        wt(1'b0);
        chk(c >= 380 && c <= 400, 1'b1, "sync_start_mode period");
        conv_in(16'h0100);
        tk(10);
        wrap_up();
    end
endmodule : aor_block_tb
`default_nettype wire
